// ==== io_chip_select_bus_mode_ctrl_tb.sv ====
`timescale 1ns/1ps
module io_chip_select_bus_mode_ctrl_tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] ctl [iocs_pkg::NUM_CS];
    logic [7:0] lbr [iocs_pkg::NUM_CS];
    logic [7:0] bmc [iocs_pkg::NUM_CS];
    logic cpu_io_req = 1'b0;
    logic cpu_rd = 1'b0;
    logic [23:0] cpu_addr = 24'h0;
    logic [7:0] cpu_wdata = 8'h0;
    logic bus_hold_request_n = 1'b1;
    logic [23:0] addr_in = 24'h0;
    logic [3:0] wait_len = 4'h0;
    logic cpu_stall, cpu_rdata_valid, wait_n, bus_hold_grant_n, io_n, rd_n, wr_n, ale, addr_oe, data_oe, int_ok;
    logic [7:0] cpu_rdata, data_out, data_in;
    logic [3:0] cs_n;
    logic [23:0] addr_out;
    logic [7:0] shadow [256];
    logic [7:0] exp_q [$];
    logic [31:0] rng = 32'd87004;
    int n_mismatch = 0;
    int tests_run = 0;
    int len_a, len_b;

    iocs_ctrl u_dut (.core_clk(core_clk), .reset_n(reset_n), .cs_control_reg(ctl), .cs_lower_bound(lbr),
        .cs_bus_mode_reg(bmc), .cpu_io_req(cpu_io_req), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_stall(cpu_stall), .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
        .wait_n(wait_n), .bus_hold_request_n(bus_hold_request_n), .bus_hold_grant_n(bus_hold_grant_n),
        .cs_n(cs_n), .io_request_strobe_n(io_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .address_latch_strobe(ale), .addr_out(addr_out), .addr_oe(addr_oe), .addr_in(addr_in),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .internal_access_ok(int_ok));
    iocs_periph_model u_periph (.core_clk(core_clk), .cs_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .addr_out(addr_out), .data_out(data_out), .wait_len(wait_len), .wait_n(wait_n), .data_in(data_in));

    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    // ---------------
    // Shared routines
    // ---------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic timeout();
        n_mismatch++;
        $display("BAD %0t wait ran out", $time);
        give_verdict();
    endtask
    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction
    // Mode 0 native, 1 legacy, 2 latch, 3 latch with multiplexed low address.
    function automatic logic [7:0] bm(input int mode, input logic [3:0] cps);
        logic [1:0] m;
        m = mode == 0 ? iocs_pkg::MODE_NATIVE : mode == 1 ? iocs_pkg::MODE_LEGACY3 : iocs_pkg::MODE_LATCH4;
        return {cps, 1'b0, mode == 3, m};
    endfunction
    // One I/O cycle; ecs 4 means no chip select may answer. Request is held until stall falls, or for five clocks if stall never rises.
    task automatic io_op(input logic rd, input logic [23:0] a, input logic [7:0] wd, input int ecs,
        input int mode, output int len);
        logic [3:0] cs_seen = 4'hf;
        logic io_lo = 1'b0;
        logic rw_lo = 1'b0;
        logic ale_hi = 1'b0;
        logic mux_bad = 1'b0;
        logic run = 1'b0;
        len = 0;
        if (rd && ecs < 4)
            exp_q.push_back(shadow[a[7:0]]);
        if (!rd && ecs < 4)
            shadow[a[7:0]] = wd;
        @(negedge core_clk);
        cpu_io_req = 1'b1;
        cpu_rd = rd;
        cpu_addr = a;
        cpu_wdata = wd;
        for (int n = 1; n < 300 && len == 0; n++)
        begin
            @(negedge core_clk);
            cs_seen &= cs_n;
            io_lo |= !io_n;
            rw_lo |= rd ? !rd_n : !wr_n;
            ale_hi |= ale;
            if (mode == 3 && ale === 1'b1 && (data_out !== a[7:0] || addr_out[7:0] !== a[7:0] || data_oe !== 1'b1))
                mux_bad = 1'b1;
            run |= cpu_stall;
            if ((run && !cpu_stall) || (!run && n > 4))
                len = n;
        end
        if (len == 0)
            timeout();
        cpu_io_req = 1'b0;
        @(negedge core_clk);
        check(cs_seen, ecs > 3 ? 4'hf : 4'(~(4'h1 << ecs)), "chip select");
        check(io_lo, ecs < 4, "io request strobe");
        check(rw_lo, ecs < 4, "read or write strobe");
        if (ecs < 4)
            check(ale_hi, mode > 1, "latch strobe");
        check(mux_bad, 0, "multiplexed low address");
    endtask
    task automatic timed(input logic [7:0] c, input logic [7:0] b, input int mode, output int len);
        ctl[0] = c;
        bmc[0] = b;
        io_op(1'b1, {rnd(), lbr[0], rnd()}, 8'h00, 0, mode, len);
    endtask

    always @(negedge core_clk)
    begin
        if (cpu_rdata_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1, 0, "unexpected read data");
            else
                check(cpu_rdata, exp_q.pop_front(), "read data");
        end
    end

    // -------------
    // Main sequence
    // -------------
    initial
    begin
        logic [23:0] a;
        for (int i = 0; i < 256; i++)
            shadow[i] = 8'(~i);
        for (int i = 0; i < 4; i++)
        begin
            ctl[i] = 8'h00;
            lbr[i] = 8'h21 + 8'(i * 17);
            bmc[i] = 8'h00;
        end
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        check(cs_n, 4'hf, "idle select");
        check(bus_hold_grant_n, 1, "idle grant");
        for (int i = 0; i < 4; i++)
            ctl[i] = 8'h18;
        // Every select runs a different mode at once, and the upper address byte is random.
        for (int m = 0; m < 4; m++)
        begin
            for (int i = 0; i < 4; i++)
                bmc[i] = bm((i + m) % 4, 4'h2);
            for (int i = 0; i < 4; i++)
            begin
                a = {rnd(), lbr[i], rnd()};
                io_op(1'b0, a, rnd(), i, (i + m) % 4, len_a);
                io_op(1'b1, a, 8'h00, i, (i + m) % 4, len_a);
            end
        end
        $display("test modes done");
        for (int i = 0; i < 4; i++)
            bmc[i] = 8'h00;
        lbr[1] = lbr[0];
        io_op(1'b1, {rnd(), lbr[0], rnd()}, 8'h00, 0, 0, len_a);
        ctl[0] = 8'h08;
        io_op(1'b1, {rnd(), lbr[0], rnd()}, 8'h00, 1, 0, len_a);
        ctl[0] = 8'h10;
        ctl[1] = 8'h08;
        io_op(1'b1, {rnd(), lbr[0], rnd()}, 8'h00, 4, 0, len_a);
        ctl[0] = 8'h18;
        ctl[1] = 8'h18;
        lbr[1] = 8'h32;
        lbr[0] = 8'h00;
        io_op(1'b1, 24'hff0080, 8'h00, 4, 0, len_a);
        io_op(1'b0, 24'h0000ff, 8'h77, 4, 0, len_a);
        io_op(1'b1, 24'h00007f, 8'h00, 0, 0, len_a);
        $display("test decode done");
        lbr[0] = 8'h21;
        timed(8'h18, bm(0, 4'h1), 0, len_a);
        timed(8'hf8, bm(0, 4'h1), 0, len_b);
        check(len_b - len_a, 7, "programmed waits");
        timed(8'h18, bm(1, 4'h1), 1, len_a);
        timed(8'h18, bm(1, 4'h4), 1, len_b);
        check(len_b - len_a, 9, "legacy state length");
        timed(8'h18, bm(2, 4'h2), 2, len_a);
        timed(8'h18, bm(2, 4'h5), 2, len_b);
        check(len_b - len_a, 12, "latch state length");
        // Seven programmed waits give the device time to pull its wait input.
        timed(8'hf8, bm(1, 4'h2), 1, len_a);
        wait_len = 4'hc;
        timed(8'hf8, bm(1, 4'h2), 1, len_b);
        wait_len = 4'h0;
        check(len_b > len_a + 2, 1, "external wait stretch");
        $display("test timing done");
        ctl[0] = 8'h18;
        bmc[0] = 8'h00;
        bus_hold_request_n = 1'b0;
        addr_in = {8'h00, lbr[2], 8'h33};
        for (int n = 0; n < 20 && bus_hold_grant_n !== 1'b0; n++)
            @(negedge core_clk);
        check(bus_hold_grant_n, 0, "grant");
        check(addr_oe, 0, "address released");
        check(int_ok, 0, "internal access");
        for (int n = 0; n < 20 && cs_n === 4'hf; n++)
            @(negedge core_clk);
        check(cs_n, 4'hb, "decode during hold");
        bus_hold_request_n = 1'b1;
        for (int n = 0; n < 20 && bus_hold_grant_n !== 1'b1; n++)
            @(negedge core_clk);
        if (bus_hold_grant_n !== 1'b1)
            timeout();
        check(int_ok, 1, "internal access restored");
        io_op(1'b1, {rnd(), lbr[3], rnd()}, 8'h00, 3, 0, len_a);
        $display("test hold done");
        check(exp_q.size(), 0, "reads left over");
        give_verdict();
    end
endmodule

// ==== iocs_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// R01: I/O chip select only during I/O instructions.
// R02: Compare only address bits 15 to 8.
// R03: Enabled, I/O space, match, lowest number wins.
// R04: Suppress select in on-chip peripheral range.
// R05: Drive select, io strobe, read/write low.
// R06: Per-select 3-bit wait count, zero to seven.
// R07: Resume first clock after wait input released.
// R08: Wait-driving peripherals need programmed wait states.
// R09: Keep adding waits while wait input low.
// R10: Bus hold request releases buses, grant low.
// R11: Decode external address during hold, no internals.
// R12: Per-select bus mode and clocks per state.
// R13: Native mode passes processor signals through.
// R14: Legacy read: address T1, strobes T2, latch T3.
// R15: Legacy waits after T2 if wait early.
// R16: Legacy write: address T1, strobes T2, T3 idle (the code keeps the write and io strobes low through T3).
// R17: Legacy states last 1 to 15 clocks.
// R18: Multiplexed option puts low address on data.
// R19: Multiplexed option keeps low address on address.
// R20: Latch strobe high start T1, low mid.
// R21: Latch-strobe read asserts read and request T2.
// R22: Latch-strobe read latches data at T4 start.
// R23: Latch-strobe states last 2 to 15 clocks.
// R24: Bit 4 selects I/O space, bit 3 enables.
// R25: Bus mode register layout chosen consistently.
module iocs_ctrl (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] cs_control_reg [iocs_pkg::NUM_CS],
    input wire logic [7:0] cs_lower_bound [iocs_pkg::NUM_CS],
    input wire logic [7:0] cs_bus_mode_reg [iocs_pkg::NUM_CS],
    input wire logic cpu_io_req,
    input wire logic cpu_rd,
    input wire logic [23:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_stall,
    output logic [7:0] cpu_rdata,
    output logic cpu_rdata_valid,
    input wire logic wait_n,
    input wire logic bus_hold_request_n,
    output logic bus_hold_grant_n,
    output logic [3:0] cs_n,
    output logic io_request_strobe_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic address_latch_strobe,
    output logic [23:0] addr_out,
    output logic addr_oe,
    input wire logic [23:0] addr_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [7:0] data_in,
    output logic internal_access_ok
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync1_r, sync2_r;
    logic [1:0] sync1_nxt;
    always_comb
    begin
        sync1_nxt = {wait_n, bus_hold_request_n};
    end
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_r <= 2'h3;
            sync2_r <= 2'h3;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync1_r;
        end
    end
    logic wait_s_n, hold_s_n;
    assign wait_s_n = sync2_r[1];
    assign hold_s_n = sync2_r[0];

    // ------------------------------------------------------------
    // Chip select decode
    // ------------------------------------------------------------
    function automatic logic [4:0] iocs_decode(input logic [15:0] a, input logic [7:0] ctl [iocs_pkg::NUM_CS],
                                               input logic [7:0] lbr [iocs_pkg::NUM_CS]);
        logic [4:0] r;
        r = 5'h00;
        // Internal peripheral window wins over every external select.
        if (!(a >= iocs_pkg::PERIPH_LO && a <= iocs_pkg::PERIPH_HI)) // see R04
        begin
            for (int i = iocs_pkg::NUM_CS - 1; i >= 0; i--) // see R03
            begin
                if (ctl[i][iocs_pkg::CTL_EN_BIT] && ctl[i][iocs_pkg::CTL_IO_BIT] && a[15:8] == lbr[i]) // see R02 R24
                begin
                    r = {1'b1, 2'(i), 2'h0};
                end
            end
        end
        return r;
    endfunction

    logic granted;
    assign granted = !bus_hold_grant_n;
    logic [4:0] cpu_hit, ext_hit;
    assign cpu_hit = iocs_decode(cpu_addr[15:0], cs_control_reg, cs_lower_bound);
    assign ext_hit = iocs_decode(addr_in[15:0], cs_control_reg, cs_lower_bound);
    assign internal_access_ok = !granted; // see R11

    // ------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------
    iocs_pkg::iocs_state_t st_r, st_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic rd_r, rd_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [2:0] wcnt_r, wcnt_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic mux_r, mux_nxt;
    logic [3:0] cps_r, cps_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic grant_r, grant_nxt;
    logic [3:0] cps_eff;

    always_comb
    begin
        cps_eff = cs_bus_mode_reg[cpu_hit[3:2]][iocs_pkg::BMC_CPS_HI:iocs_pkg::BMC_CPS_LO]; // see R12 R25
        st_nxt = st_r;
        sel_nxt = sel_r;
        rd_nxt = rd_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        cnt_nxt = cnt_r;
        wcnt_nxt = wcnt_r;
        mode_nxt = mode_r;
        mux_nxt = mux_r;
        cps_nxt = cps_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        grant_nxt = grant_r;
        case (st_r)
            iocs_pkg::ST_IDLE:
            begin
                grant_nxt = !hold_s_n; // see R10
                if (hold_s_n && !grant_r && cpu_io_req && cpu_hit[4]) // see R01
                begin
                    st_nxt = iocs_pkg::ST_T1;
                    sel_nxt = cpu_hit[3:2];
                    rd_nxt = cpu_rd;
                    addr_nxt = cpu_addr;
                    wdata_nxt = cpu_wdata;
                    wcnt_nxt = cs_control_reg[cpu_hit[3:2]][iocs_pkg::CTL_WAIT_HI:iocs_pkg::CTL_WAIT_LO]; // see R06
                    mode_nxt = cs_bus_mode_reg[cpu_hit[3:2]][1:0];
                    mux_nxt = cs_bus_mode_reg[cpu_hit[3:2]][iocs_pkg::BMC_MUX_BIT];
                    // Out-of-range state lengths are clamped to the mode minimum.
                    if (cs_bus_mode_reg[cpu_hit[3:2]][1:0] == iocs_pkg::MODE_LATCH4)
                        cps_nxt = (cps_eff < iocs_pkg::CPS_MIN_LATCH) ? iocs_pkg::CPS_MIN_LATCH : cps_eff; // see R23
                    else if (cs_bus_mode_reg[cpu_hit[3:2]][1:0] == iocs_pkg::MODE_LEGACY3)
                        cps_nxt = (cps_eff < iocs_pkg::CPS_MIN_LEGACY) ? iocs_pkg::CPS_MIN_LEGACY : cps_eff; // see R17
                    else
                        cps_nxt = iocs_pkg::CPS_MIN_LEGACY; // see R13
                    cnt_nxt = 4'h1;
                end
            end
            iocs_pkg::ST_T1, iocs_pkg::ST_T2, iocs_pkg::ST_T3, iocs_pkg::ST_T4:
            begin
                cnt_nxt = 4'(cnt_r + 4'h1);
                if (cnt_r >= cps_r)
                begin
                    cnt_nxt = 4'h1;
                    case (st_r)
                        iocs_pkg::ST_T1: st_nxt = (mode_r == iocs_pkg::MODE_NATIVE) ? iocs_pkg::ST_WAIT
                                                                               : iocs_pkg::ST_T2;
                        iocs_pkg::ST_T2: st_nxt = iocs_pkg::ST_WAIT;
                        iocs_pkg::ST_T3:
                        begin
                            if (mode_r == iocs_pkg::MODE_LATCH4)
                                st_nxt = iocs_pkg::ST_T4;
                            else
                            begin
                                st_nxt = iocs_pkg::ST_IDLE;
                                rvalid_nxt = rd_r; // see R14
                                rdata_nxt = data_in;
                            end
                        end
                        default:
                        begin
                            st_nxt = iocs_pkg::ST_IDLE;
                        end
                    endcase
                    if (st_r == iocs_pkg::ST_T3 && mode_r == iocs_pkg::MODE_LATCH4)
                    begin
                        rvalid_nxt = rd_r; // see R22
                        rdata_nxt = data_in;
                    end
                end
            end
            iocs_pkg::ST_WAIT:
            begin
                // Programmed waits first, then extend while the sampled wait input is low.
                if (wcnt_r != 3'h0)
                    wcnt_nxt = 3'(wcnt_r - 3'h1); // see R06
                else if (wait_s_n) // see R07 R09 R15 R08
                begin
                    if (mode_r == iocs_pkg::MODE_NATIVE)
                    begin
                        st_nxt = iocs_pkg::ST_IDLE;
                        rvalid_nxt = rd_r;
                        rdata_nxt = data_in;
                    end
                    else
                    begin
                        st_nxt = iocs_pkg::ST_T3;
                        cnt_nxt = 4'h1;
                    end
                end
            end
            default:
            begin
                st_nxt = iocs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= iocs_pkg::ST_IDLE;
            sel_r <= 2'h0;
            rd_r <= 1'b0;
            addr_r <= 24'h000000;
            wdata_r <= 8'h00;
            cnt_r <= 4'h1;
            wcnt_r <= 3'h0;
            mode_r <= iocs_pkg::MODE_NATIVE;
            mux_r <= 1'b0;
            cps_r <= iocs_pkg::CPS_MIN_LEGACY;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            grant_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            sel_r <= sel_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            cnt_r <= cnt_nxt;
            wcnt_r <= wcnt_nxt;
            mode_r <= mode_nxt;
            mux_r <= mux_nxt;
            cps_r <= cps_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            grant_r <= grant_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic active, strobe_on, t1_first_half;
    assign active = st_r != iocs_pkg::ST_IDLE;
    assign strobe_on = (mode_r == iocs_pkg::MODE_NATIVE) ? active
                     : (st_r == iocs_pkg::ST_T2 || st_r == iocs_pkg::ST_WAIT || st_r == iocs_pkg::ST_T3);
    assign t1_first_half = st_r == iocs_pkg::ST_T1 && cnt_r <= (cps_r >> 1);

    assign bus_hold_grant_n = !grant_r; // see R10
    assign cpu_stall = active || granted;
    assign cpu_rdata = rdata_r;
    assign cpu_rdata_valid = rvalid_r;
    always_comb
    begin
        cs_n = 4'hf;
        if (active)
            cs_n[sel_r] = 1'b0; // see R05 R14 R16
        else if (granted && ext_hit[4])
            cs_n[ext_hit[3:2]] = 1'b0; // see R11
    end
    assign io_request_strobe_n = !(active && strobe_on); // see R05 R21
    assign read_strobe_n = !(active && strobe_on && rd_r); // see R14 R21 R22
    assign write_strobe_n = !(active && strobe_on && !rd_r); // see R16
    assign address_latch_strobe = mode_r == iocs_pkg::MODE_LATCH4 && t1_first_half; // see R20
    assign addr_out = addr_r; // see R19
    assign addr_oe = !granted; // see R10
    assign data_out = (mode_r == iocs_pkg::MODE_LATCH4 && mux_r && st_r == iocs_pkg::ST_T1) ? addr_r[7:0]
                                                                                            : wdata_r; // see R18
    assign data_oe = !granted && active && (!rd_r || (mode_r == iocs_pkg::MODE_LATCH4 && mux_r
                                                      && st_r == iocs_pkg::ST_T1));

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_periph_suppress: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cpu_addr[15:0] >= iocs_pkg::PERIPH_LO && cpu_addr[15:0] <= iocs_pkg::PERIPH_HI) |-> !cpu_hit[4]) // see R04
        else $error("select decoded in peripheral range");
    a_strobe_with_cs: assert property (@(posedge core_clk) disable iff (!reset_n)
        !io_request_strobe_n |-> cs_n != 4'hf) // see R05
        else $error("io strobe without chip select");
    a_grant_release: assert property (@(posedge core_clk) disable iff (!reset_n)
        !bus_hold_grant_n |-> !addr_oe && !data_oe) // see R10
        else $error("bus driven while granted");
    a_wait_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_r == iocs_pkg::ST_WAIT && wcnt_r == 3'h0 && !wait_s_n |=> st_r == iocs_pkg::ST_WAIT) // see R09
        else $error("wait input ignored");
    a_wait_resume: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_r == iocs_pkg::ST_WAIT && wcnt_r == 3'h0 && wait_s_n |=> st_r != iocs_pkg::ST_WAIT) // see R07
        else $error("no resume after wait release");
    a_prog_waits: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_r == iocs_pkg::ST_WAIT && wcnt_r == 3'h2
        |=> st_r == iocs_pkg::ST_WAIT ##1 st_r == iocs_pkg::ST_WAIT) // see R06
        else $error("programmed waits cut short");
    a_legacy_t1: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_r == iocs_pkg::ST_T1 && mode_r == iocs_pkg::MODE_LEGACY3 |-> read_strobe_n && write_strobe_n) // see R14
        else $error("strobe in legacy T1");
    a_latch_min: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(st_r == iocs_pkg::ST_T2) && mode_r == iocs_pkg::MODE_LATCH4 |-> $past(cnt_r) >= 4'h2) // see R23
        else $error("latch state shorter than two clocks");
    a_ale_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(st_r == iocs_pkg::ST_T1) && mode_r == iocs_pkg::MODE_LATCH4 |-> address_latch_strobe) // see R20
        else $error("latch strobe not high at T1 start");
    c_legacy_read: cover property (@(posedge core_clk) disable iff (!reset_n)
        mode_r == iocs_pkg::MODE_LEGACY3 && rvalid_r);
    c_latch_mux: cover property (@(posedge core_clk) disable iff (!reset_n)
        mux_r && st_r == iocs_pkg::ST_T4);
    c_ext_wait: cover property (@(posedge core_clk) disable iff (!reset_n)
        st_r == iocs_pkg::ST_WAIT && !wait_s_n);
    c_hold_decode: cover property (@(posedge core_clk) disable iff (!reset_n)
        granted && cs_n != 4'hf);
endmodule

// ==== iocs_periph_model.sv ====
`timescale 1ns/1ps
// ----------------
// Peripheral model
// ----------------
// A byte-wide I/O device on the external bus.
// It drives a toggling value while unselected, so a read that samples too late never sees stale data.
module iocs_periph_model (
    input wire logic core_clk,
    input wire logic [3:0] cs_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [23:0] addr_out,
    input wire logic [7:0] data_out,
    input wire logic [3:0] wait_len,
    output logic wait_n,
    output logic [7:0] data_in
);
    logic [7:0] mem [256];
    logic [7:0] idle_r = 8'h5a;
    logic [3:0] wcnt_r = 4'h0;
    logic strb_r = 1'b1;
    logic sel;
    assign sel = cs_n != 4'hf;
    assign data_in = (sel && !read_strobe_n) ? mem[addr_out[7:0]] : idle_r;
    assign wait_n = wcnt_r == 4'h0;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(~i);
    end
    always @(posedge core_clk)
    begin
        idle_r <= ~idle_r;
        strb_r <= read_strobe_n & write_strobe_n;
        // Wait goes low one clock after the strobe falls, well before the programmed waits run out.
        if (sel && strb_r && !(read_strobe_n & write_strobe_n))
            wcnt_r <= wait_len;
        else if (wcnt_r != 4'h0)
            wcnt_r <= wcnt_r - 4'h1;
        if (sel && !write_strobe_n)
            mem[addr_out[7:0]] <= data_out;
    end
endmodule

// ==== iocs_pkg.sv ====
package iocs_pkg;
    localparam int NUM_CS = 4;
    // Control register fields.
    localparam int CTL_WAIT_HI = 7;
    localparam int CTL_WAIT_LO = 5;
    localparam int CTL_IO_BIT = 4;
    localparam int CTL_EN_BIT = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] LBR_RESET = 8'h00;
    // Bus mode control per chip select: [1:0] mode, [2] multiplex, [7:4] clocks per state.
    localparam int BMC_MUX_BIT = 2;
    localparam int BMC_CPS_HI = 7;
    localparam int BMC_CPS_LO = 4;
    localparam logic [7:0] BMC_RESET = 8'h00;
    localparam logic [1:0] MODE_NATIVE = 2'h0;
    localparam logic [1:0] MODE_LEGACY3 = 2'h1;
    localparam logic [1:0] MODE_LATCH4 = 2'h2;
    localparam logic [3:0] CPS_MIN_LEGACY = 4'h1;
    localparam logic [3:0] CPS_MIN_LATCH = 4'h2;
    // On-chip peripheral I/O window.
    localparam logic [15:0] PERIPH_LO = 16'h0080;
    localparam logic [15:0] PERIPH_HI = 16'h00ff;
    typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_WAIT} iocs_state_t;
endpackage
